// *** hdl/sps_mc_timer.sv ***
// machine-cycle phase sequencer: S1P1, S2P2, S5P2 and S6P2 strobes from the oscillator
// assumes ref_clk is the oscillator; 12 clocks or 6 clocks per machine cycle
`default_nettype none

module sps_mc_timer (
  input wire logic ref_clk, // oscillator clock
  input wire logic reset, // synchronous, active high
  input wire logic sixClock, // 1: six clocks per machine cycle
  output sps_pkg::sps_phase_t phase // one-clock phase strobes
);

  logic [3:0] phaseIdx_ff;
  logic [3:0] nxt_phaseIdx;
  logic [3:0] stepped;

  // -------------------------------------------------------------
  // phase counter
  // -------------------------------------------------------------
  // six-clock timing steps a whole state per clock, so P1 and P2 share it
  always_comb
  begin
    if (sixClock)
      stepped = {phaseIdx_ff[3:1], 1'b0} + 4'h2;
    else
      stepped = phaseIdx_ff + 4'h1;
    nxt_phaseIdx = (stepped >= sps_pkg::PH_COUNT) ? sps_pkg::PH_S1P1 : stepped;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      phaseIdx_ff <= sps_pkg::PH_S1P1;
    else
      phaseIdx_ff <= nxt_phaseIdx;
  end

  // -------------------------------------------------------------
  // strobe decode
  // -------------------------------------------------------------
  function automatic logic atPhase(input logic [3:0] idx, input logic [3:0] ph,
                                   input logic six);
    atPhase = six ? (idx[3:1] == ph[3:1]) : (idx == ph);
  endfunction

  // strobes decode a flop, so each lasts exactly one clock per cycle
  assign phase.s1p1 = atPhase(phaseIdx_ff, sps_pkg::PH_S1P1, sixClock);
  assign phase.s2p2 = atPhase(phaseIdx_ff, sps_pkg::PH_S2P2, sixClock);
  assign phase.s5p2 = atPhase(phaseIdx_ff, sps_pkg::PH_S5P2, sixClock);
  assign phase.s6p2 = atPhase(phaseIdx_ff, sps_pkg::PH_S6P2, sixClock);

endmodule

`default_nettype wire

// *** hdl/sps_shift_port.sv ***
// serial port in synchronous shift mode, with control flags and interrupt
// assumes a register master on ref_clk and an external shift register on
// the data and clock pins; the clock pin is driven only while a transfer runs
//
// How it works
// (RL1) shift mode: data both ways on data pin, clock on clock pin, LSB first
// (RL2) bit rate is one machine cycle: oscillator/12, or /6 in six-clock timing
// (RL3) any buffer write starts sending; marker one loaded at ninth position
// (RL4) one full machine cycle between buffer write and send-active
// (RL5) send-active routes shift output to data pin, shift clock to clock pin
// (RL6) sending: clock low in S3,S4,S5 and high in S6,S1,S2
// (RL7) S6P2 while sending: shift right, zero in from the left
// (RL8) marker next to output: last shift, end send, set transmit flag
// (RL9) receive starts on enable=1, flag=0; load 11111110, then receive-active
// (RL10) receiving: clock pin toggles at S3P1 and S6P1
// (RL11) S6P2 while receiving: receive register shifts one place
// (RL12) receive shift is leftward, bringing in data pin level sampled at S5P2
// (RL13) initial zero at left: last shift, load buffer, end receive, set flag
// (RL14) transmit flag set at end of eighth bit; software clears it
// (RL15) receive flag set by hardware, gated by multiprocessor; software clears
// (RL16) received ninth bit field untouched by shift mode
// (RL17) modes 2/3 with multiprocessor enable: no receive flag if ninth bit 0
// (RL18) buffer read returns last received byte, kept apart from transmit
//
// Decided for this implementation: strobed register access and the register addresses.
`default_nettype none

module sps_shift_port (
  input wire logic ref_clk, // oscillator clock, 10 MHz
  input wire logic reset, // synchronous, active high
  input wire logic [sps_pkg::ADDR_W-1:0] busAddr, // register address
  input wire logic [7:0] busWrData, // register write data
  input wire logic busWr, // write strobe, one cycle
  input wire logic busRd, // read strobe, one cycle
  output logic [7:0] busRdData, // read data, cycle after busRd
  input wire logic rxdIn, // data pin level
  output logic rxdOut, // data pin drive value
  output logic rxdOe, // data pin drive enable
  output logic txdOut, // shift clock pin value
  output logic txdOe, // shift clock pin drive enable
  output logic irq // level interrupt
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  sps_pkg::sps_phase_t ph;
  sps_pkg::sps_ctrl_t ctrl_ff, nxt_ctrl;
  sps_pkg::sps_tx_state_t txState_ff, nxt_txState;
  sps_pkg::sps_rx_state_t rxState_ff, nxt_rxState;
  logic [1:0] intStat_ff, nxt_intStat;
  logic [1:0] intMask_ff, nxt_intMask;
  logic sixClock_ff, nxt_sixClock;
  logic [7:0] rdData_ff, nxt_rdData;
  logic [8:0] txShift_ff, nxt_txShift;
  logic [7:0] rxShift_ff, nxt_rxShift;
  logic [7:0] rxHold_ff, nxt_rxHold;
  logic rxBit_ff, nxt_rxBit;
  logic clkLevel_ff, nxt_clkLevel;
  logic rxdMeta_ff, rxdSync_ff;
  logic modeShift;
  logic bufWr;
  logic txDone;
  logic rxDone;
  logic rxSet;
  logic rxStart;
  logic sending;
  logic receiving;

  // ---------------------------------------------------------------
  // machine-cycle timing
  // ---------------------------------------------------------------
  // (RL2) one bit per machine cycle
  sps_mc_timer u_timer (
    .ref_clk(ref_clk),
    .reset(reset),
    .sixClock(sixClock_ff),
    .phase(ph)
  );

  // ---------------------------------------------------------------
  // pin input synchroniser
  // ---------------------------------------------------------------
  // the data pin belongs to the outside world; only rxdSync_ff is read
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      rxdMeta_ff <= 1'b1;
      rxdSync_ff <= 1'b1;
    end
    else
    begin
      rxdMeta_ff <= rxdIn;
      rxdSync_ff <= rxdMeta_ff;
    end
  end

  // common qualifiers
  assign modeShift = (ctrl_ff.mode == sps_pkg::MODE_SHIFT);
  assign bufWr = busWr && (busAddr == sps_pkg::ADR_BUFFER) && modeShift;
  assign sending = (txState_ff == sps_pkg::TX_SEND);
  assign receiving = (rxState_ff == sps_pkg::RX_SHIFT) || (rxState_ff == sps_pkg::RX_LAST);
  // the data pin is shared, so a reception waits for the sender to idle
  assign rxStart = ctrl_ff.rx_enable && !ctrl_ff.receive_flag && modeShift
                   && (txState_ff == sps_pkg::TX_IDLE) && !bufWr;

  // ---------------------------------------------------------------
  // transmit engine
  // ---------------------------------------------------------------
  // next state of the send sequence and its nine-bit shift register
  always_comb
  begin
    nxt_txState = txState_ff;
    nxt_txShift = txShift_ff;
    txDone = 1'b0;
    unique case (txState_ff)
      sps_pkg::TX_IDLE:
        nxt_txState = sps_pkg::TX_IDLE;
      // (RL3) write taken at S6P2
      sps_pkg::TX_ARM:
        if (ph.s6p2)
          nxt_txState = sps_pkg::TX_WAIT;
      // (RL4) wait one machine cycle
      sps_pkg::TX_WAIT:
        if (ph.s6p2)
          nxt_txState = sps_pkg::TX_SEND;
      sps_pkg::TX_SEND:
      begin
        // (RL8) end after last shift
        if (ph.s1p1 && (txShift_ff == sps_pkg::TX_EMPTY))
        begin
          nxt_txState = sps_pkg::TX_IDLE;
          txDone = 1'b1;
        end
        // (RL7) shift right, zero fill
        if (ph.s6p2)
          nxt_txShift = {1'b0, txShift_ff[8:1]};
      end
    endcase
    // (RL3) any write restarts sending
    if (bufWr)
    begin
      nxt_txShift = {1'b1, busWrData};
      nxt_txState = sps_pkg::TX_ARM;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      txState_ff <= sps_pkg::TX_IDLE;
      txShift_ff <= sps_pkg::TX_EMPTY;
    end
    else
    begin
      txState_ff <= nxt_txState;
      txShift_ff <= nxt_txShift;
    end
  end

  // ---------------------------------------------------------------
  // receive engine
  // ---------------------------------------------------------------
  // bits arrive leftward, so the first (least significant) bit ends on the
  // left; the buffer load mirrors them back into LSB-first order
  function automatic logic [7:0] mirror(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
      r[i] = v[7 - i];
    return r;
  endfunction

  // next state of the receive sequence, shift register and holding byte
  always_comb
  begin
    nxt_rxState = rxState_ff;
    nxt_rxShift = rxShift_ff;
    nxt_rxHold = rxHold_ff;
    nxt_rxBit = rxBit_ff;
    rxDone = 1'b0;
    // (RL12) sample data pin at S5P2
    if (ph.s5p2)
      nxt_rxBit = rxdSync_ff;
    unique case (rxState_ff)
      // (RL9) start on enable and clear flag
      sps_pkg::RX_IDLE:
        if (rxStart && ph.s6p2)
          nxt_rxState = sps_pkg::RX_ARM;
      // (RL9) load pattern one cycle later
      sps_pkg::RX_ARM:
        if (!rxStart)
          nxt_rxState = sps_pkg::RX_IDLE;
        else if (ph.s6p2)
        begin
          nxt_rxShift = sps_pkg::RX_INIT;
          nxt_rxState = sps_pkg::RX_SHIFT;
        end
      sps_pkg::RX_SHIFT:
        // (RL11) shift at S6P2
        if (ph.s6p2)
        begin
          // (RL12) left shift, sample in
          nxt_rxShift = {rxShift_ff[6:0], rxBit_ff};
          // (RL13) marker zero at left
          if (!rxShift_ff[7])
            nxt_rxState = sps_pkg::RX_LAST;
        end
      sps_pkg::RX_LAST:
        // (RL13) load buffer at S1P1
        if (ph.s1p1)
        begin
          // (RL18) separate holding byte
          nxt_rxHold = mirror(rxShift_ff);
          nxt_rxState = sps_pkg::RX_IDLE;
          rxDone = 1'b1;
        end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      rxState_ff <= sps_pkg::RX_IDLE;
      rxShift_ff <= sps_pkg::RX_INIT;
      rxHold_ff <= sps_pkg::READ_IDLE;
      rxBit_ff <= 1'b1;
    end
    else
    begin
      rxState_ff <= nxt_rxState;
      rxShift_ff <= nxt_rxShift;
      rxHold_ff <= nxt_rxHold;
      rxBit_ff <= nxt_rxBit;
    end
  end

  // ---------------------------------------------------------------
  // shift clock and pins
  // ---------------------------------------------------------------
  // the level register turns one phase early, so the pin itself changes at
  // S3P1 and S6P1; in six-clock timing this keeps the rise off the data shift
  always_comb
  begin
    nxt_clkLevel = clkLevel_ff;
    // (RL6) low from S3 through S5
    // (RL10) pin falls at S3P1
    if (ph.s2p2)
      nxt_clkLevel = 1'b0;
    // (RL10) pin rises at S6P1
    else if (ph.s5p2)
      nxt_clkLevel = 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      clkLevel_ff <= 1'b1;
    else
      clkLevel_ff <= nxt_clkLevel;
  end

  // (RL5) route output bit and clock
  // (RL1) data out on data pin
  assign rxdOut = txShift_ff[0];
  assign rxdOe = sending;
  // (RL10) clock also while receiving
  assign txdOut = clkLevel_ff;
  assign txdOe = sending || receiving;

  // ---------------------------------------------------------------
  // receive flag gating
  // ---------------------------------------------------------------
  // shift mode has no ninth bit, so the gate stays open there
  function automatic logic rxFlagGate(input logic [1:0] mode, input logic mpe,
                                      input logic ninth);
    logic nineBit;
    nineBit = (mode == sps_pkg::MODE_NINE_FIXED) || (mode == sps_pkg::MODE_NINE_VAR);
    return !(nineBit && mpe && !ninth);
  endfunction

  // (RL15) hardware sets receive flag
  // (RL17) multiprocessor gate
  assign rxSet = rxDone && rxFlagGate(ctrl_ff.mode, ctrl_ff.multiprocessor_enable, 1'b0);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // software writes first, hardware sets after, so a set beats a clear
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_intStat = intStat_ff;
    nxt_intMask = intMask_ff;
    nxt_sixClock = sixClock_ff;
    nxt_rdData = sps_pkg::READ_IDLE;
    if (busWr)
    begin
      unique case (busAddr)
        // (RL16) ninth-bit field software-only
        sps_pkg::ADR_CONTROL:
          nxt_ctrl = sps_pkg::sps_ctrl_t'(busWrData);
        sps_pkg::ADR_INT_STATUS:
          nxt_intStat = intStat_ff & ~busWrData[1:0];
        sps_pkg::ADR_INT_MASK:
          nxt_intMask = busWrData[1:0];
        sps_pkg::ADR_CONFIG:
          nxt_sixClock = busWrData[0];
        default:
          nxt_intMask = intMask_ff;
      endcase
    end
    // (RL14) transmit flag at end
    if (txDone)
    begin
      nxt_ctrl.transmit_flag = 1'b1;
      nxt_intStat[sps_pkg::INT_TX] = 1'b1;
    end
    // (RL13) receive flag at end
    if (rxSet)
    begin
      nxt_ctrl.receive_flag = 1'b1;
      nxt_intStat[sps_pkg::INT_RX] = 1'b1;
    end
    if (busRd)
    begin
      unique case (busAddr)
        sps_pkg::ADR_CONTROL:
          nxt_rdData = ctrl_ff;
        // (RL18) read returns received byte
        sps_pkg::ADR_BUFFER:
          nxt_rdData = rxHold_ff;
        sps_pkg::ADR_INT_STATUS:
          nxt_rdData = {6'h00, intStat_ff};
        sps_pkg::ADR_INT_MASK:
          nxt_rdData = {6'h00, intMask_ff};
        sps_pkg::ADR_CONFIG:
          nxt_rdData = {5'h00, receiving, sending, sixClock_ff};
        default:
          nxt_rdData = sps_pkg::READ_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ctrl_ff <= sps_pkg::CONTROL_RST;
      intStat_ff <= sps_pkg::INT_RST;
      intMask_ff <= sps_pkg::INT_RST;
      sixClock_ff <= 1'b0;
      rdData_ff <= sps_pkg::READ_IDLE;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      intStat_ff <= nxt_intStat;
      intMask_ff <= nxt_intMask;
      sixClock_ff <= nxt_sixClock;
      rdData_ff <= nxt_rdData;
    end
  end

  assign busRdData = rdData_ff;
  // level interrupt, high while any unmasked event is pending
  assign irq = |(intStat_ff & intMask_ff);

endmodule

`default_nettype wire

// *** pkg/sps_pkg.sv ***
// shared constants and carrier types of the shift-mode serial port
// assumes one oscillator clock and a plain register port with 3 address bits
`default_nettype none

package sps_pkg;

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam logic [ADDR_W-1:0] ADR_CONTROL = 3'h0;
  localparam logic [ADDR_W-1:0] ADR_BUFFER = 3'h1;
  localparam logic [ADDR_W-1:0] ADR_INT_STATUS = 3'h2;
  localparam logic [ADDR_W-1:0] ADR_INT_MASK = 3'h3;
  localparam logic [ADDR_W-1:0] ADR_CONFIG = 3'h4;

  // reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [1:0] INT_RST = 2'h0;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // interrupt status / mask bit positions
  localparam int INT_TX = 0;
  localparam int INT_RX = 1;

  // ---------------------------------------------------------------
  // serial modes and shift patterns
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_NINE_FIXED = 2'h2;
  localparam logic [1:0] MODE_NINE_VAR = 2'h3;
  localparam logic [8:0] TX_EMPTY = 9'h001;
  localparam logic [7:0] RX_INIT = 8'hfe;

  // ---------------------------------------------------------------
  // machine cycle: six states of two phases, S1P1 is index 0
  // ---------------------------------------------------------------
  localparam logic [3:0] PH_COUNT = 4'hc;
  localparam logic [3:0] PH_S1P1 = 4'h0;
  localparam logic [3:0] PH_S2P2 = 4'h3;
  localparam logic [3:0] PH_S5P2 = 4'h9;
  localparam logic [3:0] PH_S6P2 = 4'hb;

  // one-clock strobes of the machine-cycle phases the port uses
  typedef struct packed {
    logic s1p1;
    logic s2p2;
    logic s5p2;
    logic s6p2;
  } sps_phase_t;

  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] mode;
    logic multiprocessor_enable;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic transmit_flag;
    logic receive_flag;
  } sps_ctrl_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_ARM = 2'b01,
    TX_WAIT = 2'b11,
    TX_SEND = 2'b10
  } sps_tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_ARM = 2'b01,
    RX_SHIFT = 2'b11,
    RX_LAST = 2'b10
  } sps_rx_state_t;

endpackage

`default_nettype wire

// *** verification/sps_port_monitor.sv ***
// checker of the shift-mode serial port, watching only the top ports
// assumes mode 0 traffic and no buffer write while a transfer runs
`default_nettype none

module sps_port_monitor (
  input wire logic ref_clk, // oscillator clock
  input wire logic reset, // synchronous, active high
  input wire logic [sps_pkg::ADDR_W-1:0] busAddr, // register address
  input wire logic [7:0] busWrData, // register write data
  input wire logic busWr, // write strobe
  input wire logic busRd, // read strobe
  input wire logic [7:0] busRdData, // read data
  input wire logic rxdIn, // data pin level
  input wire logic rxdOut, // data pin drive value
  input wire logic rxdOe, // data pin enable
  input wire logic txdOut, // shift clock value
  input wire logic txdOe, // shift clock enable
  input wire logic irq // interrupt
);
  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  logic sixMode_ff, nxt_sixMode, txdPrev_ff, nxt_txdPrev;
  logic [6:0] oeCnt_ff, nxt_oeCnt;
  logic [3:0] lowCnt_ff, nxt_lowCnt, riseCnt_ff, nxt_riseCnt;

  // track timing mode from config writes; length of enable, clock low, rises
  always_comb
  begin
    nxt_sixMode = (busWr && busAddr == sps_pkg::ADR_CONFIG) ? busWrData[0] : sixMode_ff;
    nxt_txdPrev = txdOut;
    nxt_oeCnt = txdOe ? oeCnt_ff + 7'h1 : 7'h0;
    nxt_lowCnt = (txdOe && !txdOut) ? lowCnt_ff + 4'h1 : 4'h0;
    nxt_riseCnt = !txdOe ? 4'h0 : riseCnt_ff + {3'h0, txdOut && !txdPrev_ff};
  end

  // registers only
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      sixMode_ff <= 1'b0;
      txdPrev_ff <= 1'b1;
      oeCnt_ff <= 7'h0;
      lowCnt_ff <= 4'h0;
      riseCnt_ff <= 4'h0;
    end
    else
    begin
      sixMode_ff <= nxt_sixMode;
      txdPrev_ff <= nxt_txdPrev;
      oeCnt_ff <= nxt_oeCnt;
      lowCnt_ff <= nxt_lowCnt;
      riseCnt_ff <= nxt_riseCnt;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  chk_read_idle_zero: assert property (!$past(busRd) |-> busRdData == 8'h00)
    else $error("read data not zero outside read answer");
  chk_send_oe_pair: assert property (rxdOe |-> txdOe)
    else $error("data driven without shift clock");
  chk_send_end_together: assert property ($fell(rxdOe) |-> $fell(txdOe))
    else $error("send end not aligned with clock release");
  chk_xfer_cycle_len: assert property ($fell(txdOe) |->
    oeCnt_ff == (sixMode_ff ? 7'h31 : 7'h61))
    else $error("transfer not eight machine cycles long");
  chk_eight_clock_rises: assert property ($fell(txdOe) |-> riseCnt_ff == 4'h8)
    else $error("transfer did not give eight clock rises");
  chk_clock_low_states: assert property ($rose(txdOut) && txdOe |->
    lowCnt_ff == (sixMode_ff ? 4'h3 : 4'h6))
    else $error("shift clock low period wrong");
  chk_data_after_rise: assert property ($changed(rxdOut) && rxdOe && $past(rxdOe) |->
    txdOut && (sixMode_ff ? !$past(txdOut, 2) : !$past(txdOut, 3)))
    else $error("data moved away from the S6P2 shift");
  chk_send_start_twelve: assert property (busWr && busAddr == sps_pkg::ADR_BUFFER &&
    !sixMode_ff && !txdOe |-> ##[13:25] $rose(rxdOe))
    else $error("send did not start one machine cycle after write");
  chk_send_start_six: assert property (busWr && busAddr == sps_pkg::ADR_BUFFER &&
    sixMode_ff && !txdOe |-> ##[7:13] $rose(rxdOe))
    else $error("six-clock send did not start in time");
  chk_recv_start_time: assert property (busWr && busAddr == sps_pkg::ADR_CONTROL &&
    busWrData[7:4] == 4'h1 && !busWrData[0] && !txdOe && !sixMode_ff
    |-> ##[13:25] ($rose(txdOe) && !rxdOe))
    else $error("receive did not start in time");
endmodule

bind sps_shift_port sps_port_monitor sps_port_monitor_inst (.ref_clk, .reset, .busAddr,
  .busWrData, .busWr, .busRd, .busRdData, .rxdIn, .rxdOut, .rxdOe, .txdOut, .txdOe, .irq);

`default_nettype wire

// *** verification/sps_shift_peer.sv ***
// external shift register on the data and clock pins of the serial port
// assumes the bench resolves the data pin with a pull-up
`default_nettype none

module sps_shift_peer (
  input wire logic ref_clk, // oscillator, used to sample the pins
  input wire logic txdOut, // shift clock pin
  input wire logic txdOe, // shift clock enable
  input wire logic rxdOe, // device drives data pin
  input wire logic rxdLine, // resolved data pin
  input wire logic [7:0] sendByte, // byte to hand to the device
  output logic rxdDrive, // data pin value from peer
  output logic rxdDriveEn, // peer drives data pin
  output logic [7:0] gotByte = 8'h00, // byte taken from the device
  output logic [3:0] gotCount = 4'h0 // bits taken
);
  logic prevClk = 1'b1;
  logic prevLine = 1'b1;
  logic prevOe = 1'b0;
  logic [3:0] idx = 4'h0;

  // sample half a cycle off, using the level seen before the clock rose,
  // so a data change on the same edge as the clock is not taken
  // lsb first
  always @(negedge ref_clk)
  begin
    if (txdOe && !prevOe)
    begin
      gotCount <= 4'h0;
      idx <= 4'h0;
    end
    else if (txdOe && txdOut && !prevClk)
    begin
      if (rxdOe)
      begin
        gotByte <= {prevLine, gotByte[7:1]};
        gotCount <= gotCount + 4'h1;
      end
      idx <= idx + 4'h1;
    end
    prevClk <= txdOut;
    prevLine <= rxdLine;
    prevOe <= txdOe;
  end

  // drive only while the device receives; released pin falls to the pull-up
  assign rxdDriveEn = txdOe && !rxdOe;
  assign rxdDrive = sendByte[idx[2:0]];
endmodule

`default_nettype wire

// *** verification/test_serial_port_shift_mode.sv ***
// testbench of the shift-mode serial port with an external shift register
// assumes package, design, peer and bound monitor are compiled before it
`default_nettype none

module test_serial_port_shift_mode;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [sps_pkg::ADDR_W-1:0] busAddr = 3'h0;
  logic [7:0] busWrData = 8'h00;
  logic busWr = 1'b0;
  logic busRd = 1'b0;
  logic [7:0] peerSend = 8'h00;
  logic [7:0] busRdData, peerGot;
  logic [3:0] peerCount;
  logic rxdIn, rxdOut, rxdOe, txdOut, txdOe, irq, peerDrive, peerEn;
  int fail_count = 0;
  int checked = 0;

  // data pin has a pull-up; whichever side enables drives it
  assign rxdIn = rxdOe ? rxdOut : (peerEn ? peerDrive : 1'b1);
  always #50 ref_clk = ~ref_clk;

  sps_shift_port sps_shift_port_inst (.ref_clk(ref_clk), .reset(reset), .busAddr(busAddr),
    .busWrData(busWrData), .busWr(busWr), .busRd(busRd), .busRdData(busRdData),
    .rxdIn(rxdIn), .rxdOut(rxdOut), .rxdOe(rxdOe), .txdOut(txdOut), .txdOe(txdOe),
    .irq(irq));
  sps_shift_peer sps_shift_peer_inst (.ref_clk(ref_clk), .txdOut(txdOut), .txdOe(txdOe),
    .rxdOe(rxdOe), .rxdLine(rxdIn), .sendByte(peerSend), .rxdDrive(peerDrive),
    .rxdDriveEn(peerEn), .gotByte(peerGot), .gotCount(peerCount));

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    busWr <= 1'b1;
    busAddr <= a;
    busWrData <= d;
    @(posedge ref_clk);
    busWr <= 1'b0;
  endtask

  // one-cycle read strobe; data stands only in the following cycle
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    busRd <= 1'b1;
    busAddr <= a;
    @(posedge ref_clk);
    busRd <= 1'b0;
    #1 d = busRdData;
  endtask

  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    check(v, exp);
  endtask

  // poll a control flag under a bound
  task automatic wait_flag(input int bitIdx);
    logic [7:0] v;
    for (int i = 0; i < 400; i++)
    begin
      rd(sps_pkg::ADR_CONTROL, v);
      if (v[bitIdx] === 1'b1)
        return;
    end
    fail_count++;
    $display("unexpected at %0t: flag wait ran out", $time);
    finish_test();
  endtask

  task automatic irqchk(input logic exp);
    @(posedge ref_clk);
    #1 check({7'h0, irq}, {7'h0, exp});
  endtask

  task automatic t_reset();
    // all places but the buffer read zero, unmapped ones too
    for (int a = 0; a < 8; a++)
      if (a != 1)
        rdchk(a[2:0], 8'h00);
    irqchk(1'b0);
    $display("test reset values done");
  endtask

  task automatic t_send(input logic [7:0] b, input logic six);
    wr(sps_pkg::ADR_CONFIG, {7'h0, six});
    wr(sps_pkg::ADR_INT_MASK, 8'h03);
    wr(sps_pkg::ADR_BUFFER, b);
    repeat (30) @(posedge ref_clk);
    rdchk(sps_pkg::ADR_CONFIG, {6'h01, six});
    wait_flag(1);
    check(peerGot, b);
    check({4'h0, peerCount}, 8'h08);
    irqchk(1'b1);
    rdchk(sps_pkg::ADR_INT_STATUS, 8'h01);
    rdchk(sps_pkg::ADR_CONTROL, 8'h02);
    wr(sps_pkg::ADR_CONTROL, 8'h00);
    wr(sps_pkg::ADR_INT_STATUS, 8'h01);
    rdchk(sps_pkg::ADR_CONTROL, 8'h00);
    irqchk(1'b0);
    $display("test send %h done", b);
  endtask

  task automatic t_recv(input logic [7:0] b, input logic six);
    wr(sps_pkg::ADR_CONFIG, {7'h0, six});
    wr(sps_pkg::ADR_INT_MASK, 8'h00);
    peerSend <= b;
    wr(sps_pkg::ADR_CONTROL, 8'h10);
    repeat (30) @(posedge ref_clk);
    rdchk(sps_pkg::ADR_CONFIG, {6'h02, six});
    wait_flag(0);
    // stop reception in the same write that clears the flag, or a new one starts
    wr(sps_pkg::ADR_CONTROL, 8'h00);
    rdchk(sps_pkg::ADR_BUFFER, b);
    rdchk(sps_pkg::ADR_INT_STATUS, 8'h02);
    irqchk(1'b0);
    wr(sps_pkg::ADR_INT_MASK, 8'h02);
    irqchk(1'b1);
    wr(sps_pkg::ADR_INT_STATUS, 8'h02);
    irqchk(1'b0);
    rdchk(sps_pkg::ADR_BUFFER, b);
    $display("test receive %h done", b);
  endtask

  // main sequence
  initial
  begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_send(8'ha5, 1'b0);
    t_send(8'h81, 1'b1);
    t_recv(8'h3c, 1'b0);
    t_recv(8'hc5, 1'b1);
    finish_test();
  end
endmodule

`default_nettype wire
